// *** design/cp_consts.svh ***
// Purpose: named constants for the charge pump mode and dimming control
// Assumes: 125 MHz core clock
// Notes:   times in their own units, cycle counts derived in the module
`ifndef CP_CONSTS_SVH
`define CP_CONSTS_SVH
`define CLK_PERIOD_NS     8
`define SHDN_LOW_TIME_NS  20000000
`define PULSE_LOW_MIN_NS  200
`define UNITY_HYS_MV      13'h12c
`define LEVEL_FULL        6'h20
`define LEVEL_LOW         6'h01
`define LEVEL_STEP        6'h01
`define CHANNELS          6
`define GAIN_SETTLE_CYC   16
`define VIN_W             13
`endif

// *** design/cp_pkg.sv ***
// Purpose: types shared by the charge pump mode and dimming control
// Assumes: nothing
// Notes:   one-hot codes written out
package cp_pkg;
  typedef enum logic [3:0]
  {
    GAIN_1X   = 4'b0001,
    GAIN_133X = 4'b0010,
    GAIN_15X  = 4'b0100,
    GAIN_2X   = 4'b1000
  } gain_t;

  typedef enum logic [1:0]
  {
    ST_SHUT = 2'b01,
    ST_RUN  = 2'b10
  } run_state_t;

  typedef struct packed
  {
    logic       dim;
    logic       pwm;
    logic       uv;
    logic       headroom_low;
  } host_in_t;

  typedef struct packed
  {
    logic [5:0] sink_en;
    logic [5:0] level;
  } drive_t;
endpackage

// *** design/charge_pump_mode_and_dimming_ctrl.sv ***
// Purpose: gain selection, one-wire dimming count, pwm gating, shutdown
// Assumes: analog side supplies headroom flag, undervoltage flag, vin in mV
// Notes:   sink enable low means the sink is high-impedance
//
// Functional notes
// (RL1) After power-up select unity gain, supply passed straight to output.
// (RL2) Stay in unity gain while all channels have enough headroom.
// (RL3) Lost headroom in unity gain steps up to 1.33x by itself.
// (RL4) Same test in 1.33x and 1.5x steps up further, ending at 2x.
// (RL5) Sufficient supply returns straight to unity gain, never one step down.
// (RL6) Return level sits 300 mV above the level where unity was left.
// (RL7) Undervoltage below 1.8 V disables every channel and shuts down.
// (RL8) First rising dimming edge sets full-scale current, 25 mA.
// (RL9) Each later pulse lowers the shared level by one 1/32 step.
// (RL10) Pwm high drives all six channels at the programmed level.
// (RL11) Pwm low forces all channel currents to zero.
// (RL12) Dimming or pwm input low for 20 ms shuts the device down.
// (RL13) In shutdown all six sinks are high-impedance with no current.
// (RL14) Dimming and pwm inputs are both active high.
// (RL15) Rising edges count pulses; current is full scale times (32-n)/32.
// (RL16) After 31 pulses at the lowest level the next wraps to full scale.
// (RL17) Host keeps pulses 200 ns to 100 us; shorter lows are ignored.
// (RL18) Leaving shutdown restarts unity gain, full scale on enabling edge.
// (RL19) Inputs are synchronised; low-time counters reset by any high.
`timescale 1ns/1ps
`default_nettype none
`include "cp_consts.svh"

module charge_pump_mode_and_dimming_ctrl #(
  parameter int SHDN_CYCLES = `SHDN_LOW_TIME_NS / `CLK_PERIOD_NS,
  parameter int SETTLE_CYC  = `GAIN_SETTLE_CYC
) (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  // host pins
  input  wire logic                    dimming_pulse_input,
  input  wire logic                    pwm_in,
  // analog indications
  input  wire logic                    uv_low,
  input  wire logic                    headroom_low,
  input  wire logic [`VIN_W-1:0]       vin_mv,
  // controls to the analog side
  output var  cp_pkg::gain_t           gain_q,
  output var  cp_pkg::drive_t          drive_q,
  output var  logic                    shutdown_q
);

  // *****************************************************
  // constants and checks
  // *****************************************************
  localparam int CW      = $clog2(SHDN_CYCLES + 1);
  localparam int LOW_CYC = (`PULSE_LOW_MIN_NS + `CLK_PERIOD_NS - 1) /
                           `CLK_PERIOD_NS;
  localparam logic [CW-1:0] SHDN_C = CW'(SHDN_CYCLES);
  localparam logic [CW-1:0] LOW_C  = CW'(LOW_CYC);
  localparam logic [4:0]    SET_C  = 5'(SETTLE_CYC);

  // refuse settings that the counters cannot serve
  if (SHDN_CYCLES <= LOW_CYC || SETTLE_CYC < 1 || SETTLE_CYC > 31)
  begin : g_param_chk
    $error("charge pump control: parameter out of range");
  end

  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    sat_inc = (v == SHDN_C) ? v : v + CW'(1);
  endfunction

  function automatic cp_pkg::gain_t next_gain(input cp_pkg::gain_t g);
    case (g)
      cp_pkg::GAIN_1X:   next_gain = cp_pkg::GAIN_133X;
      cp_pkg::GAIN_133X: next_gain = cp_pkg::GAIN_15X;
      default:           next_gain = cp_pkg::GAIN_2X;
    endcase
  endfunction

  // *****************************************************
  // input synchronisers and low-time counters
  // *****************************************************
  cp_pkg::host_in_t meta_q, sync_q, prev_q;
  logic [CW-1:0]    dim_lo_q, dim_lo_d;
  logic [CW-1:0]    pwm_lo_q, pwm_lo_d;
  logic             edge_ok, shdn_req;

  always_comb
  begin
    // any high level clears its count [RL19]
    dim_lo_d = sync_q.dim ? '0 : sat_inc(dim_lo_q);
    pwm_lo_d = sync_q.pwm ? '0 : sat_inc(pwm_lo_q);
    // active high: rising edge after a long enough low [RL14] [RL15] [RL17]
    edge_ok  = sync_q.dim && !prev_q.dim && (dim_lo_q >= LOW_C);
    shdn_req = (dim_lo_q == SHDN_C) || (pwm_lo_q == SHDN_C); // [RL12]
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q   <= '0;
      sync_q   <= '0;
      prev_q   <= '0;
      dim_lo_q <= '0;
      pwm_lo_q <= '0;
    end
    else
    begin
      meta_q   <= '{dimming_pulse_input, pwm_in, uv_low, headroom_low}; // [RL19]
      sync_q   <= meta_q;
      prev_q   <= sync_q;
      dim_lo_q <= dim_lo_d;
      pwm_lo_q <= pwm_lo_d;
    end
  end

  // *****************************************************
  // run state and dimming level
  // *****************************************************
  cp_pkg::run_state_t st_q, st_d;
  logic [5:0]         level_q, level_d;

  always_comb
  begin
    st_d    = st_q;
    level_d = level_q;
    case (st_q)
      cp_pkg::ST_SHUT:
      begin
        if (edge_ok && !sync_q.uv)
        begin
          st_d    = cp_pkg::ST_RUN;
          level_d = `LEVEL_FULL; // [RL8] [RL18]
        end
      end
      cp_pkg::ST_RUN:
      begin
        if (sync_q.uv || shdn_req)
          st_d = cp_pkg::ST_SHUT; // [RL7] [RL12]
        else if (edge_ok)
        begin
          if (level_q == `LEVEL_LOW)
            level_d = `LEVEL_FULL; // [RL16]
          else
            level_d = level_q - `LEVEL_STEP; // [RL9] [RL15]
        end
      end
      default:
        st_d = cp_pkg::ST_SHUT;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q    <= cp_pkg::ST_SHUT;
      level_q <= `LEVEL_FULL;
    end
    else
    begin
      st_q    <= st_d;
      level_q <= level_d;
    end
  end

  // *****************************************************
  // pump gain selection
  // *****************************************************
  cp_pkg::gain_t        gain_d;
  logic [`VIN_W:0]      exit_mv_q, exit_mv_d;
  logic [4:0]           settle_q, settle_d;
  logic                 vin_ok;

  always_comb
  begin
    gain_d    = gain_q;
    exit_mv_d = exit_mv_q;
    settle_d  = (settle_q == 5'h00) ? settle_q : settle_q - 5'h01;
    // return point sits a fixed margin above the exit point [RL6]
    vin_ok    = {1'b0, vin_mv} >= exit_mv_q + {1'b0, `UNITY_HYS_MV};
    if (st_d == cp_pkg::ST_SHUT)
    begin
      gain_d   = cp_pkg::GAIN_1X; // [RL1] [RL18]
      settle_d = SET_C;
    end
    else if (gain_q != cp_pkg::GAIN_1X && vin_ok)
    begin
      gain_d   = cp_pkg::GAIN_1X; // [RL5]
      settle_d = SET_C;
    end
    else if (sync_q.headroom_low && settle_q == 5'h00 &&
             gain_q != cp_pkg::GAIN_2X)
    begin
      gain_d   = next_gain(gain_q); // [RL2] [RL3] [RL4]
      settle_d = SET_C;
      if (gain_q == cp_pkg::GAIN_1X)
        exit_mv_d = {1'b0, vin_mv};
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gain_q    <= cp_pkg::GAIN_1X;
      exit_mv_q <= '0;
      settle_q  <= '0;
    end
    else
    begin
      gain_q    <= gain_d;
      exit_mv_q <= exit_mv_d;
      settle_q  <= settle_d;
    end
  end

  // *****************************************************
  // channel gating
  // *****************************************************
  cp_pkg::drive_t drive_d;
  logic           shutdown_d;

  always_comb
  begin
    shutdown_d    = (st_d == cp_pkg::ST_SHUT);
    drive_d.level = level_d;
    // pwm gates all channels; shutdown leaves sinks open [RL10] [RL11] [RL13]
    drive_d.sink_en = (!shutdown_d && sync_q.pwm) ? '1 : '0;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      drive_q    <= '{sink_en: 6'h00, level: `LEVEL_FULL};
      shutdown_q <= 1'b1;
    end
    else
    begin
      drive_q    <= drive_d;
      shutdown_q <= shutdown_d;
    end
  end

  // *****************************************************
  // assertions
  // *****************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  shut_unity_a: assert property ( // [RL1]
    shutdown_q |-> gain_q == cp_pkg::GAIN_1X)
    else $error("gain not unity in shutdown");

  hold_unity_a: assert property ( // [RL2]
    st_q == cp_pkg::ST_RUN && gain_q == cp_pkg::GAIN_1X
    && !sync_q.headroom_low |=> gain_q == cp_pkg::GAIN_1X)
    else $error("left unity gain with headroom");

  step_order_a: assert property ( // [RL3] [RL4]
    $changed(gain_q) && gain_q != cp_pkg::GAIN_1X
    |-> gain_q == next_gain($past(gain_q)))
    else $error("gain skipped or stepped down");

  unity_return_a: assert property ( // [RL5] [RL6]
    st_d == cp_pkg::ST_RUN && gain_q != cp_pkg::GAIN_1X && vin_ok
    |=> gain_q == cp_pkg::GAIN_1X)
    else $error("no return to unity gain");

  uv_shutdown_a: assert property ( // [RL7] [RL13]
    sync_q.uv |=> shutdown_q && drive_q.sink_en == 6'h00)
    else $error("undervoltage did not shut down");

  first_edge_a: assert property ( // [RL8] [RL18]
    st_q == cp_pkg::ST_SHUT && edge_ok && !sync_q.uv
    |=> !shutdown_q && drive_q.level == `LEVEL_FULL)
    else $error("enable edge did not load full scale");

  level_dec_a: assert property ( // [RL9] [RL15]
    st_q == cp_pkg::ST_RUN && edge_ok && !sync_q.uv && !shdn_req
    && level_q != `LEVEL_LOW |=> level_q == $past(level_q) - `LEVEL_STEP)
    else $error("level not decremented by one");

  level_wrap_a: assert property ( // [RL16]
    st_q == cp_pkg::ST_RUN && edge_ok && !sync_q.uv && !shdn_req
    && level_q == `LEVEL_LOW |=> level_q == `LEVEL_FULL)
    else $error("level did not wrap to full scale");

  pwm_on_a: assert property ( // [RL10]
    st_d == cp_pkg::ST_RUN && sync_q.pwm |=> drive_q.sink_en == 6'h3f)
    else $error("channels off with pwm high");

  pwm_off_a: assert property ( // [RL11]
    !sync_q.pwm |=> drive_q.sink_en == 6'h00)
    else $error("channels on with pwm low");

  low_shutdown_a: assert property ( // [RL12]
    st_q == cp_pkg::ST_RUN && shdn_req |=> shutdown_q)
    else $error("long low did not shut down");

  short_low_a: assert property ( // [RL17]
    sync_q.dim && !prev_q.dim && dim_lo_q < LOW_C |=> $stable(level_q))
    else $error("short low pulse was counted");

endmodule
`default_nettype wire

// *** tb/dim_host.sv ***
// Purpose: host model driving the dimming and pwm pins
// Assumes: one core clock, pins driven just after its rising edge
// Notes:   both pins are active high and idle high once enabled
`timescale 1ns/1ps
`default_nettype none

module dim_host (
  // clock
  input  wire logic core_clk,
  // host pins
  output var  logic dimming_pulse_input,
  output var  logic pwm_in
);
  initial
  begin
    dimming_pulse_input = 1'b0;
    pwm_in              = 1'b1;
  end

  // low for low_cyc cycles, then high for 30
  task automatic pulse(input int low_cyc);
    @(posedge core_clk) dimming_pulse_input <= 1'b0;
    repeat (low_cyc) @(posedge core_clk);
    dimming_pulse_input <= 1'b1;
    repeat (30) @(posedge core_clk);
  endtask

  // a long low here requests shutdown
  task automatic set_pwm(input logic v);
    @(posedge core_clk) pwm_in <= v;
  endtask
endmodule

`default_nettype wire

// *** tb/charge_pump_mode_and_dimming_ctrl_test.sv ***
// Purpose: self-checking bench for the pump mode and dimming control
// Assumes: 125 MHz clock, shutdown count shortened to 200 cycles
// Notes:   dimming steps and the wrap to full scale run from a table
`timescale 1ns/1ps
`default_nettype none

module charge_pump_mode_and_dimming_ctrl_test;
  typedef struct packed
  {
    logic [5:0] n;
    logic [5:0] level;
  } row_t;

  logic           core_clk;
  logic           resetn;
  logic           uv_low;
  logic           headroom_low;
  logic [12:0]    vin_mv;
  wire            dim;
  wire            pwm;
  cp_pkg::gain_t  gain_q;
  cp_pkg::drive_t drive_q;
  logic           shutdown_q;
  int             n_errors;
  int             samples_checked;
  row_t           rows [4];

  dim_host host (
    .core_clk            (core_clk),
    .dimming_pulse_input (dim),
    .pwm_in              (pwm)
  );

  charge_pump_mode_and_dimming_ctrl #(
    .SHDN_CYCLES (200)
  ) uut (
    .core_clk            (core_clk),
    .resetn              (resetn),
    .dimming_pulse_input (dim),
    .pwm_in              (pwm),
    .uv_low              (uv_low),
    .headroom_low        (headroom_low),
    .vin_mv              (vin_mv),
    .gain_q              (gain_q),
    .drive_q             (drive_q),
    .shutdown_q          (shutdown_q)
  );

  // ********************************
  // helpers
  // ********************************
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [5:0] exp,
                     input logic [5:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic state(input logic [3:0] g, input logic [5:0] en,
                       input logic [5:0] lv, input logic sd);
    chk("gain", {2'h0, g}, {2'h0, gain_q});
    chk("sink_en", en, drive_q.sink_en);
    chk("level", lv, drive_q.level);
    chk("shutdown", {5'h00, sd}, {5'h00, shutdown_q});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    summarize();
  end

  // ********************************
  // tests
  // ********************************
  initial
  begin
    n_errors        = 0;
    samples_checked = 0;
    resetn          = 1'b0;
    uv_low          = 1'b0;
    headroom_low    = 1'b0;
    vin_mv          = 13'h0bb8;
    rows = '{'{6'h01, 6'h1f}, '{6'h04, 6'h1b},
             '{6'h1a, 6'h01}, '{6'h01, 6'h20}};
    wait_cyc(1);
    state(4'h1, 6'h00, 6'h20, 1'b1);
    @(posedge core_clk) resetn <= 1'b1;
    wait_cyc(1);
    state(4'h1, 6'h00, 6'h20, 1'b1);
    $display("test reset done");
    host.pulse(30);
    wait_cyc(1);
    state(4'h1, 6'h3f, 6'h20, 1'b0);
    $display("test enable done");
    foreach (rows[i])
    begin
      repeat (rows[i].n) host.pulse(30);
      wait_cyc(1);
      state(4'h1, 6'h3f, rows[i].level, 1'b0);
    end
    $display("test dimming table done");
    host.pulse(10);
    wait_cyc(1);
    state(4'h1, 6'h3f, 6'h20, 1'b0);
    $display("test short low done");
    host.set_pwm(1'b0);
    wait_cyc(20);
    state(4'h1, 6'h00, 6'h20, 1'b0);
    host.set_pwm(1'b1);
    wait_cyc(5);
    state(4'h1, 6'h3f, 6'h20, 1'b0);
    $display("test pwm gate done");
    @(posedge core_clk) headroom_low <= 1'b1;
    wait_cyc(8);
    chk("gain", 6'h02, {2'h0, gain_q});
    wait_cyc(80);
    chk("gain", 6'h08, {2'h0, gain_q});
    @(posedge core_clk) headroom_low <= 1'b0;
    vin_mv <= 13'h0ce3;
    wait_cyc(10);
    chk("gain", 6'h08, {2'h0, gain_q});
    @(posedge core_clk) vin_mv <= 13'h0ce4;
    wait_cyc(4);
    chk("gain", 6'h01, {2'h0, gain_q});
    $display("test gain done");
    @(posedge core_clk) uv_low <= 1'b1;
    vin_mv <= 13'h1fff;
    wait_cyc(5);
    state(4'h1, 6'h00, 6'h20, 1'b1);
    @(posedge core_clk) uv_low <= 1'b0;
    host.pulse(30);
    wait_cyc(1);
    state(4'h1, 6'h3f, 6'h20, 1'b0);
    $display("test undervoltage done");
    @(posedge core_clk) vin_mv <= 13'h0000;
    headroom_low <= 1'b1;
    wait_cyc(8);
    chk("gain", 6'h02, {2'h0, gain_q});
    @(posedge core_clk) headroom_low <= 1'b0;
    vin_mv <= 13'h012b;
    wait_cyc(10);
    chk("gain", 6'h02, {2'h0, gain_q});
    @(posedge core_clk) vin_mv <= 13'h012c;
    wait_cyc(4);
    chk("gain", 6'h01, {2'h0, gain_q});
    $display("test low exit level done");
    host.set_pwm(1'b0);
    wait_cyc(150);
    chk("shutdown", 6'h00, {5'h00, shutdown_q});
    wait_cyc(60);
    state(4'h1, 6'h00, 6'h20, 1'b1);
    host.set_pwm(1'b1);
    $display("test long low done");
    summarize();
  end
endmodule

`default_nettype wire
